// ### hw/supply_control_supervisor.sv
// Regulator and switch enables, reset, status flags and interrupt
`timescale 1ns/1ps
module supply_control_supervisor
    import supply_pkg::*;
#(
    parameter int PULSE_CYCLES = RESET_CYCLES
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic enable_in,
    // Mode and configuration
    input wire op_mode_t mode_in,
    input wire logic battery_present_in,
    input wire logic sw_normal_on_in,
    input wire logic sw_standby_on_in,
    input wire logic sw_sleep_cyclic_in,
    input wire logic cyclic_window_in,
    input wire logic aux_restart_in,
    input wire logic [FLAG_COUNT-1:0] irq_mask_in,
    // Status read strobes
    input wire logic reset_status_read_in,
    input wire logic overtemp_status_read_in,
    input wire logic supply_status_read_in,
    // Analog comparators
    input wire logic [CMP_COUNT-1:0] cmp_raw_in,
    // Enables and reset
    output logic main_regulator_en_out,
    output logic aux_regulator_en_out,
    output logic battery_switch_en_out,
    output logic mcu_reset_out_n,
    // Status
    output logic reset_status_reg_out,
    output logic [3:0] overtemp_status_reg_out,
    output logic [3:0] supply_status_reg_out,
    output logic irq_out
);
    supply_if cmp ();
    logic [CMP_COUNT-1:0] lvl;
    logic [CMP_COUNT-1:0] lvl_prev_r;
    logic [CMP_COUNT-1:0] rise;
    logic reset_active;
    logic reset_flag_r;
    logic [FLAG_COUNT-1:0] flags_r;
    logic [FLAG_COUNT-1:0] flag_set;
    logic [FLAG_COUNT-1:0] flag_clr;
    logic main_hot_r;
    logic aux_off_r;
    logic main_en;
    logic aux_en;
    logic sw_en;
    logic reset_active_prev_r;

    cmp_sync u_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .enable_in(enable_in),
        .raw_in(cmp_raw_in),
        .sync_out(cmp)
    );
    assign lvl = cmp.level;

    reset_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .enable_in(enable_in),
        .trigger_in(lvl[CMP_MAIN_UV]),
        .active_out(reset_active)
    );

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            lvl_prev_r <= '0;
        else if (enable_in)
            lvl_prev_r <= lvl;
    end
    assign rise = lvl & ~lvl_prev_r;

    // Event map onto sticky flags
    always_comb
    begin
        flag_set = '0;
        flag_set[FLAG_MAIN_WARN] = rise[CMP_MAIN_WARN];
        flag_set[FLAG_MAIN_SHUT] = rise[CMP_MAIN_SHUT];
        flag_set[FLAG_AUX_WARN] = rise[CMP_AUX_WARN];
        flag_set[FLAG_AUX_SHUT] = rise[CMP_AUX_SHUT];
        flag_set[FLAG_AUX_UV] = rise[CMP_AUX_UV];
        flag_set[FLAG_SW_HOT] = rise[CMP_SW_HOT];
        flag_set[FLAG_BAT_LOW] = rise[CMP_BAT_LOW];
        flag_set[FLAG_BAT_HIGH] = rise[CMP_BAT_HIGH];
    end

    always_comb
    begin
        flag_clr = '0;
        flag_clr[FLAG_MAIN_WARN] = overtemp_status_read_in;
        flag_clr[FLAG_MAIN_SHUT] = overtemp_status_read_in;
        flag_clr[FLAG_AUX_WARN] = overtemp_status_read_in;
        flag_clr[FLAG_AUX_SHUT] = overtemp_status_read_in;
        flag_clr[FLAG_AUX_UV] = supply_status_read_in;
        flag_clr[FLAG_SW_HOT] = supply_status_read_in;
        flag_clr[FLAG_BAT_LOW] = supply_status_read_in;
        flag_clr[FLAG_BAT_HIGH] = supply_status_read_in;
    end

    // Set beats clear so an event in the read cycle survives
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi++)
        begin : g_flag
            always_ff @(posedge clock_in or posedge rst_in)
            begin
                if (rst_in)
                    flags_r[gi] <= FLAGS_RESET[gi];
                else if (enable_in)
                begin
                    if (flag_set[gi])
                        flags_r[gi] <= 1'b1;
                    else if (flag_clr[gi])
                        flags_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            reset_active_prev_r <= 1'b0;
        else if (enable_in)
            reset_active_prev_r <= reset_active;
    end

    // Reset cause flag, set on each undervoltage reset
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            reset_flag_r <= 1'b0;
        else if (enable_in)
        begin
            if (rise[CMP_MAIN_UV])
                reset_flag_r <= 1'b1;
            else if (reset_status_read_in)
                reset_flag_r <= 1'b0;
        end
    end

    // Main thermal latch: off at shut-off, back once under pre-warning
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            main_hot_r <= 1'b0;
        else if (enable_in)
        begin
            if (lvl[CMP_MAIN_SHUT])
                main_hot_r <= 1'b1;
            else if (!lvl[CMP_MAIN_WARN])
                main_hot_r <= 1'b0;
        end
    end

    // Aux latch holds off until host restarts it
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            aux_off_r <= 1'b0;
        else if (enable_in)
        begin
            if (lvl[CMP_AUX_SHUT])
                aux_off_r <= 1'b1;
            else if (aux_restart_in)
                aux_off_r <= 1'b0;
        end
    end

    always_comb
    begin
        main_en = 1'b0;
        unique case (mode_in)
            MODE_NORMAL_REQUEST, MODE_NORMAL, MODE_STANDBY: main_en = 1'b1;
            MODE_SLEEP, MODE_EMERGENCY: main_en = reset_active;
            default: main_en = 1'b0;
        endcase
        // Emergency and sleep stay off even during reset
        if (mode_in == MODE_SLEEP || mode_in == MODE_EMERGENCY)
            main_en = 1'b0;
        if (main_hot_r || lvl[CMP_MAIN_SHUT] || !battery_present_in)
            main_en = 1'b0;
    end

    assign aux_en = (mode_in == MODE_NORMAL) && !aux_off_r
        && !lvl[CMP_AUX_SHUT] && main_en;

    always_comb
    begin
        sw_en = 1'b0;
        unique case (mode_in)
            MODE_NORMAL: sw_en = sw_normal_on_in;
            MODE_STANDBY: sw_en = sw_standby_on_in;
            MODE_SLEEP: sw_en = sw_sleep_cyclic_in && cyclic_window_in;
            MODE_NORMAL_REQUEST, MODE_EMERGENCY: sw_en = 1'b0;
            default: sw_en = 1'b0;
        endcase
        // Thermal and upstream faults override configuration
        if (lvl[CMP_SW_HOT] || aux_off_r || lvl[CMP_AUX_SHUT] || !main_en)
            sw_en = 1'b0;
    end

    // Enables registered for glitch-free pins
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            main_regulator_en_out <= 1'b0;
            aux_regulator_en_out <= 1'b0;
            battery_switch_en_out <= 1'b0;
            mcu_reset_out_n <= 1'b0;
        end
        else if (enable_in)
        begin
            main_regulator_en_out <= main_en;
            aux_regulator_en_out <= aux_en;
            battery_switch_en_out <= sw_en;
            mcu_reset_out_n <= !reset_active;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            irq_out <= 1'b0;
        else if (enable_in)
            irq_out <= |(flags_r & irq_mask_in);
    end

    assign reset_status_reg_out = reset_flag_r;
    assign overtemp_status_reg_out = flags_r[FLAG_AUX_SHUT:FLAG_MAIN_WARN];
    assign supply_status_reg_out = flags_r[FLAG_BAT_HIGH:FLAG_AUX_UV];

    property p_uv_reset;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        lvl[CMP_MAIN_UV] |=> !mcu_reset_out_n;
    endproperty
    a_uv_reset: assert property (p_uv_reset) else $error("reset not asserted on undervoltage");

    property p_uv_flag;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        rise[CMP_MAIN_UV] |=> reset_flag_r;
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("reset flag not set");

    property p_main_shut;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        lvl[CMP_MAIN_SHUT] |=> !main_regulator_en_out;
    endproperty
    a_main_shut: assert property (p_main_shut) else $error("main not off at shut-off");

    property p_main_warn;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        rise[CMP_MAIN_WARN] |=> flags_r[FLAG_MAIN_WARN];
    endproperty
    a_main_warn: assert property (p_main_warn) else $error("main warn flag missing");

    property p_aux_latch;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        aux_off_r && !aux_restart_in |=> aux_off_r;
    endproperty
    a_aux_latch: assert property (p_aux_latch) else $error("aux restarted unasked");

    property p_aux_needs_main;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        // Outputs frozen by a low enable reflect older inputs
        aux_regulator_en_out && $past(enable_in)
            |-> $past(main_en) && $past(mode_in) == MODE_NORMAL;
    endproperty
    a_aux_needs_main: assert property (p_aux_needs_main) else $error("aux on illegally");

    property p_sw_hot;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        lvl[CMP_SW_HOT] |=> !battery_switch_en_out;
    endproperty
    a_sw_hot: assert property (p_sw_hot) else $error("switch closed while hot");

    sequence s_bat_low_seen;
        rise[CMP_BAT_LOW] && irq_mask_in[FLAG_BAT_LOW];
    endsequence

    sequence s_irq_after_flag;
        ##1 irq_out;
    endsequence

    property p_bat_low;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        s_bat_low_seen |=> s_irq_after_flag;
    endproperty
    a_bat_low: assert property (p_bat_low) else $error("battery low irq missing");

    // Limitation: assumes a pulse of at least eight cycles
    sequence s_uv_leaves;
        $fell(lvl[CMP_MAIN_UV]);
    endsequence

    sequence s_reset_holds;
        !mcu_reset_out_n [*8];
    endsequence

    property p_uv_stretch;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        s_uv_leaves |=> s_reset_holds;
    endproperty
    a_uv_stretch: assert property (p_uv_stretch) else $error("reset pulse short");

    sequence s_pulse_ends;
        reset_active_prev_r && !reset_active;
    endsequence

    property p_reset_release;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        s_pulse_ends |=> mcu_reset_out_n;
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("reset stuck");

    property p_main_recover;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        main_hot_r && !lvl[CMP_MAIN_SHUT] && !lvl[CMP_MAIN_WARN] |=> !main_hot_r;
    endproperty
    a_main_recover: assert property (p_main_recover) else $error("main not restored");

    property p_main_off;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        (mode_in == MODE_SLEEP || mode_in == MODE_EMERGENCY || !battery_present_in)
            |=> !main_regulator_en_out;
    endproperty
    a_main_off: assert property (p_main_off) else $error("main on illegally");

    property p_aux_off;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        mode_in != MODE_NORMAL |=> !aux_regulator_en_out;
    endproperty
    a_aux_off: assert property (p_aux_off) else $error("aux on outside normal");

    property p_aux_restart;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        aux_off_r && aux_restart_in && !lvl[CMP_AUX_SHUT] |=> !aux_off_r;
    endproperty
    a_aux_restart: assert property (p_aux_restart) else $error("aux not restarted");

    property p_sw_upstream;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        !main_en || aux_off_r |=> !battery_switch_en_out;
    endproperty
    a_sw_upstream: assert property (p_sw_upstream) else $error("switch not opened");

    property p_supply_hold;
        @(posedge clock_in) disable iff (rst_in || !enable_in)
        |(~supply_status_reg_out & $past(supply_status_reg_out))
            |-> $past(supply_status_read_in);
    endproperty
    a_supply_hold: assert property (p_supply_hold) else $error("supply flag lost");
endmodule // supply_control_supervisor

// ### hw/supply_pkg.sv
// Constants and types for the supply control supervisor
package supply_pkg;
    typedef enum logic [2:0] {
        MODE_NORMAL_REQUEST,
        MODE_NORMAL,
        MODE_STANDBY,
        MODE_SLEEP,
        MODE_EMERGENCY
    } op_mode_t;
    localparam int RESET_TIME_NS = 1000000;
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int RESET_CYCLES = (RESET_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int CMP_COUNT = 9;
    localparam int CMP_MAIN_UV = 0;
    localparam int CMP_MAIN_WARN = 1;
    localparam int CMP_MAIN_SHUT = 2;
    localparam int CMP_AUX_UV = 3;
    localparam int CMP_AUX_WARN = 4;
    localparam int CMP_AUX_SHUT = 5;
    localparam int CMP_SW_HOT = 6;
    localparam int CMP_BAT_LOW = 7;
    localparam int CMP_BAT_HIGH = 8;
    localparam int FLAG_COUNT = 8;
    localparam int FLAG_MAIN_WARN = 0;
    localparam int FLAG_MAIN_SHUT = 1;
    localparam int FLAG_AUX_WARN = 2;
    localparam int FLAG_AUX_SHUT = 3;
    localparam int FLAG_AUX_UV = 4;
    localparam int FLAG_SW_HOT = 5;
    localparam int FLAG_BAT_LOW = 6;
    localparam int FLAG_BAT_HIGH = 7;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
endpackage

// ### hw/supply_if.sv
// Interface carrying synchronised comparator levels
`timescale 1ns/1ps
interface supply_if;
    import supply_pkg::*;
    logic [CMP_COUNT-1:0] level;
    modport src (output level);
    modport dst (input level);
endinterface

// ### hw/cmp_sync.sv
// Two-flop synchroniser for analog comparator outputs
`timescale 1ns/1ps
module cmp_sync
    import supply_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic enable_in,
    // Raw comparators
    input wire logic [CMP_COUNT-1:0] raw_in,
    // Synchronised
    supply_if.src sync_out
);
    logic [CMP_COUNT-1:0] meta_r;
    logic [CMP_COUNT-1:0] stable_r;

    // Only stable_r reads meta_r
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_r <= '0;
            stable_r <= '0;
        end
        else if (enable_in)
        begin
            meta_r <= raw_in;
            stable_r <= meta_r;
        end
    end
    assign sync_out.level = stable_r;
endmodule // cmp_sync

// ### hw/reset_pulse.sv
// Reset pulse generator, held with its trigger and then a fixed length after it
`timescale 1ns/1ps
module reset_pulse
    import supply_pkg::*;
#(
    parameter int PULSE_CYCLES = RESET_CYCLES
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic enable_in,
    // Trigger and pulse
    input wire logic trigger_in,
    output logic active_out
);
    localparam int CW = $clog2(PULSE_CYCLES + 1);
    logic [CW-1:0] count_r;

    // Held while trigger present, then full pulse length after it leaves
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            count_r <= CW'(PULSE_CYCLES);
        else if (enable_in)
        begin
            if (trigger_in)
                count_r <= CW'(PULSE_CYCLES);
            else if (count_r != '0)
                count_r <= count_r - CW'(1);
        end
    end
    assign active_out = (count_r != '0) || trigger_in;
endmodule // reset_pulse

// ### sim/host_model.sv
// Host microcontroller model issuing status read strobes
`timescale 1ns/1ps
module host_model
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Device side
    input wire logic mcu_reset_in_n,
    input wire logic [2:0] read_req_in,
    // Read strobes
    output logic [2:0] read_out
);
    // No reads while held in reset, strobe follows the request one cycle later
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            read_out <= 3'h0;
        else
            read_out <= read_req_in & {3{mcu_reset_in_n}};
    end
endmodule // host_model

// ### sim/supply_control_supervisor_bench.sv
// Self-checking bench for the supply control supervisor
`timescale 1ns/1ps
module supply_control_supervisor_bench;
    import supply_pkg::*;
    localparam int P = 20;
    typedef struct {op_mode_t m; logic [4:0] cfg; logic [8:0] raw; logic [2:0] en;} row_t;
    logic clock_in, rst_in, bat_r, swn_r, sws_r, swc_r, win_r, restart_r, enable_r;
    op_mode_t mode_r;
    logic [7:0] mask_r;
    logic [2:0] req_r, rd;
    logic [8:0] raw_r;
    logic main_en, aux_en, sw_en, rst_n, reset_status_reg, irq;
    logic [3:0] ots, sss;
    int error_cnt = 0;
    int n_checks = 0;
    int cmap [8] = '{1, 2, 4, 5, 3, 6, 7, 8};
    // Config bits are {battery, normal on, standby on, sleep cyclic, window}
    row_t rows [12] = '{
        '{MODE_NORMAL_REQUEST, 5'h1F, 9'h000, 3'h4},
        '{MODE_NORMAL, 5'h18, 9'h000, 3'h7},
        '{MODE_NORMAL, 5'h10, 9'h000, 3'h6},
        '{MODE_STANDBY, 5'h14, 9'h000, 3'h5},
        '{MODE_STANDBY, 5'h18, 9'h000, 3'h4},
        '{MODE_SLEEP, 5'h1F, 9'h000, 3'h0},
        '{MODE_EMERGENCY, 5'h1F, 9'h000, 3'h0},
        '{MODE_NORMAL, 5'h08, 9'h000, 3'h0},
        '{MODE_NORMAL, 5'h18, 9'h040, 3'h6},
        '{MODE_NORMAL, 5'h18, 9'h006, 3'h0},
        '{MODE_NORMAL, 5'h18, 9'h000, 3'h7},
        '{MODE_NORMAL, 5'h18, 9'h180, 3'h7}};

    supply_control_supervisor #(.PULSE_CYCLES(P)) uut (.clock_in(clock_in), .rst_in(rst_in),
        .enable_in(enable_r), .mode_in(mode_r), .battery_present_in(bat_r),
        .sw_normal_on_in(swn_r), .sw_standby_on_in(sws_r), .sw_sleep_cyclic_in(swc_r),
        .cyclic_window_in(win_r), .aux_restart_in(restart_r), .irq_mask_in(mask_r),
        .reset_status_read_in(rd[0]), .overtemp_status_read_in(rd[1]),
        .supply_status_read_in(rd[2]), .cmp_raw_in(raw_r), .main_regulator_en_out(main_en),
        .aux_regulator_en_out(aux_en), .battery_switch_en_out(sw_en), .mcu_reset_out_n(rst_n),
        .reset_status_reg_out(reset_status_reg), .overtemp_status_reg_out(ots),
        .supply_status_reg_out(sss), .irq_out(irq));

    host_model host (.clock_in(clock_in), .rst_in(rst_in), .mcu_reset_in_n(rst_n),
        .read_req_in(req_r), .read_out(rd));

    initial
    begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    // Bounded count of cycles until the reset output releases
    task automatic span(input string what, input int lo, input int hi);
        int n;
        n = 0;
        while (rst_n !== 1'b1 && n < 400)
        begin
            wt(1);
            n++;
        end
        n_checks++;
        if (n < lo || n > hi)
        begin
            error_cnt++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, n);
        end
        if (n >= 400)
            summarize();
    endtask

    task automatic read_grp(input logic [2:0] g);
        @(posedge clock_in);
        req_r <= g;
        @(posedge clock_in);
        req_r <= 3'h0;
        wt(3);
    endtask

    initial
    begin
        rst_in = 1'b1;
        enable_r = 1'b1;
        {bat_r, swn_r, sws_r, swc_r, win_r, restart_r} = 6'h20;
        mode_r = MODE_NORMAL_REQUEST;
        mask_r = 8'h00;
        req_r = 3'h0;
        raw_r = 9'h000;
        wt(1);
        chk("reset outputs", 8'h00, {3'h0, main_en, aux_en, sw_en, rst_n, irq});
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        span("reset release", P, P + 2);
        foreach (rows[i])
        begin
            @(posedge clock_in);
            mode_r <= rows[i].m;
            {bat_r, swn_r, sws_r, swc_r, win_r} <= rows[i].cfg;
            raw_r <= rows[i].raw;
            wt(6);
            chk("enables", {5'h0, rows[i].en}, {5'h0, main_en, aux_en, sw_en});
        end
        // Undervoltage pulse, then stretch after it leaves
        @(posedge clock_in);
        raw_r <= 9'h001;
        wt(6);
        chk("uv reset", 8'h03, {5'h0, rst_n, reset_status_reg, main_en});
        @(posedge clock_in);
        raw_r <= 9'h000;
        span("uv stretch", P + 1, P + 5);
        read_grp(3'h7);
        chk("status cleared", 8'h00, {sss, ots});
        chk("reset flag cleared", 8'h00, {7'h0, reset_status_reg});
        for (int f = 0; f < 8; f++)
        begin
            @(posedge clock_in);
            raw_r <= 9'h001 << cmap[f];
            mask_r <= 8'h00;
            wt(6);
            chk("irq masked", 8'h00, {7'h0, irq});
            @(posedge clock_in);
            mask_r <= 8'h01 << f;
            wt(3);
            chk("flags", 8'h01 << f, {sss, ots});
            chk("irq", 8'h01, {7'h0, irq});
            @(posedge clock_in);
            raw_r <= 9'h000;
            wt(6);
            chk("flag held", 8'h01 << f, {sss, ots});
            read_grp(f < 4 ? 3'h2 : 3'h4);
            chk("flag read", 8'h00, {sss, ots});
            chk("irq cleared", 8'h00, {7'h0, irq});
        end
        // Aux shut-off stays latched until restart
        chk("aux latched", 8'h04, {5'h0, main_en, aux_en, sw_en});
        @(posedge clock_in);
        restart_r <= 1'b1;
        @(posedge clock_in);
        restart_r <= 1'b0;
        wt(6);
        chk("aux restart", 8'h07, {5'h0, main_en, aux_en, sw_en});
        // Main stays off until back below pre-warning
        @(posedge clock_in);
        raw_r <= 9'h006;
        wt(6);
        @(posedge clock_in);
        raw_r <= 9'h002;
        wt(6);
        chk("main still hot", 8'h00, {5'h0, main_en, aux_en, sw_en});
        @(posedge clock_in);
        raw_r <= 9'h000;
        wt(6);
        chk("main cooled", 8'h07, {5'h0, main_en, aux_en, sw_en});
        // Low clock enable must hide a mode change
        @(posedge clock_in);
        enable_r <= 1'b0;
        mode_r <= MODE_SLEEP;
        wt(6);
        chk("frozen", 8'h07, {5'h0, main_en, aux_en, sw_en});
        @(posedge clock_in);
        enable_r <= 1'b1;
        wt(6);
        chk("unfrozen", 8'h00, {5'h0, main_en, aux_en, sw_en});
        // Mask enabled before the event
        @(posedge clock_in);
        mode_r <= MODE_NORMAL;
        mask_r <= 8'h40;
        raw_r <= 9'h080;
        wt(6);
        chk("irq battery low", 8'h01, {7'h0, irq});
        // Mid-run reset clears state and restarts the pulse
        @(posedge clock_in);
        rst_in <= 1'b1;
        raw_r <= 9'h000;
        wt(2);
        chk("mid reset outputs", 8'h00, {3'h0, main_en, aux_en, sw_en, rst_n, irq});
        chk("mid reset flags", 8'h00, {sss, ots});
        repeat (4) @(posedge clock_in);
        rst_in <= 1'b0;
        span("reset again", P, P + 2);
        summarize();
    end
endmodule // supply_control_supervisor_bench
